//--- design/ppfr_defines.svh
`ifndef PPFR_DEFINES_SVH
`define PPFR_DEFINES_SVH
// timing
`define PPFR_CLK_HZ 32'h05F5_E100
`define PPFR_TICK_MS 32'h2
`define PPFR_TICK_CYC (`PPFR_CLK_HZ / 32'h3E8 * `PPFR_TICK_MS)
`define PPFR_TICKS_PER_10MS 32'h5
`define PPFR_TICKS_PER_100MS 32'h32
// scaling: percent in 0.01 % steps, gain in 0.1 steps
`define PPFR_FULL 32'sh2710
`define PPFR_KP_UNITY 32'sh3E8
`define PPFR_ACC_SH 16
`define PPFR_RAMP_NUM 32'sh7D0
// register indices, byte address is index * 4
`define PPFR_NREG 28
`define PPFR_NWR 24
`define PPFR_R_CTRL 5'h00
`define PPFR_R_TGT 5'h01
`define PPFR_R_RANGE 5'h02
`define PPFR_R_KP1 5'h03
`define PPFR_R_TI1 5'h04
`define PPFR_R_TD1 5'h05
`define PPFR_R_KP2 5'h06
`define PPFR_R_TI2 5'h07
`define PPFR_R_TD2 5'h08
`define PPFR_R_REVCUT 5'h09
`define PPFR_R_DEVLIM 5'h0A
`define PPFR_R_DIFLIM 5'h0B
`define PPFR_R_CHGT 5'h0C
`define PPFR_R_FBFLT 5'h0D
`define PPFR_R_OUTFLT 5'h0E
`define PPFR_R_SWDEV1 5'h0F
`define PPFR_R_SWDEV2 5'h10
`define PPFR_R_INIT 5'h11
`define PPFR_R_HOLDT 5'h12
`define PPFR_R_STEPF 5'h13
`define PPFR_R_STEPR 5'h14
`define PPFR_R_LOSSTHR 5'h15
`define PPFR_R_LOSST 5'h16
`define PPFR_R_FMAX 5'h17
`define PPFR_R_STATUS 5'h18
`define PPFR_R_TGTDISP 5'h19
`define PPFR_R_FBDISP 5'h1A
`define PPFR_R_OUT 5'h1B
// control fields
`define PPFR_C_TSRC 2:0
`define PPFR_C_FSRC 6:3
`define PPFR_C_REV 7
`define PPFR_C_SWMODE 9:8
`define PPFR_C_PAUSE_EN 10
`define PPFR_C_LIMSTOP 11
`define PPFR_C_RUNSTOP 12
// status fields
`define PPFR_S_FAULT 0
`define PPFR_S_HOLD 1
`define PPFR_S_SET2 2
// reset values
`define PPFR_RV_TGT 16'h1388
`define PPFR_RV_RANGE 16'h03E8
`define PPFR_RV_KP 16'h00C8
`define PPFR_RV_TI 16'h00C8
`define PPFR_RV_REVCUT 16'h00C8
`define PPFR_RV_DEVLIM 16'h0001
`define PPFR_RV_DIFLIM 16'h000A
`define PPFR_RV_SWDEV1 16'h07D0
`define PPFR_RV_SWDEV2 16'h1F40
`define PPFR_RV_STEP 16'h0064
`define PPFR_RV_LOSST 16'h000A
`define PPFR_RV_FMAX 16'h1388
`endif

//--- design/ppfr_pkg.sv
`default_nettype none
package ppfr_pkg;
  typedef enum logic [1:0] {
    PPFR_IDLE = 2'h0,
    PPFR_HOLD = 2'h1,
    PPFR_RUN = 2'h3
  } ppfr_state_t;
  typedef logic signed [31:0] ppfr_val_t;
endpackage
`default_nettype wire

//--- design/ppfr_top.sv
// Operation
// RULE_01 - target source: digital, three analogs, pulse, comm
// RULE_02 - feedback source: nine codes incl. sum, max, min
// RULE_03 - forward/reverse action, inverted by input
// RULE_04 - display scales 100 % to range value
// RULE_05 - gain 100.0 maps full error to fmax
// RULE_06 - integral reaches fmax in integral time
// RULE_07 - differential reaches fmax within diff time
// RULE_08 - negative output capped at reverse cut-off
// RULE_09 - small deviation holds output steady
// RULE_10 - differential term clamped to its limit
// RULE_11 - target ramps linearly over change time
// RULE_12 - separate feedback and output low-pass filters
// RULE_13 - gain set: none, by input, automatic
// RULE_14 - automatic mode interpolates between deviations
// RULE_15 - start forces initial value for hold time
// RULE_16 - 2 ms updates, step limited per direction
// RULE_17 - integral pause input when enabled
// RULE_18 - integral stops at output limit when enabled
// RULE_19 - low feedback beyond time raises loss fault
// RULE_20 - option keeps regulating while stopped
// RULE_21 - target and feedback are 0 to 100 %
// RULE_22 - sum terms each tick, scale, clamp, filter
// RULE_23 - reset clears integral, filters, ramp, timer
//
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
`include "ppfr_defines.svh"
`default_nettype none
module ppfr_top
  import ppfr_pkg::*;
#(
  parameter int TICK_CYC = `PPFR_TICK_CYC
)
(
  input wire logic I_MCLK,
  input wire logic I_RST_B,
  input wire logic [7:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  input wire logic [15:0] I_ANALOG_INPUT_ONE,
  input wire logic [15:0] I_ANALOG_INPUT_TWO,
  input wire logic [15:0] I_ANALOG_INPUT_THREE,
  input wire logic [15:0] I_PULSE_FREQUENCY_INPUT,
  input wire logic [15:0] I_COMM_VALUE,
  input wire logic I_DRIVE_RUN,
  input wire logic I_DI_ACTION_INVERT,
  input wire logic I_DI_GAIN_SET_TWO,
  input wire logic I_DI_INTEG_PAUSE,
  output logic signed [31:0] O_FREQ_CORR,
  output logic O_UPDATE,
  output logic O_FEEDBACK_LOSS_FAULT
);
  function automatic ppfr_val_t clamp(input ppfr_val_t v, lo, hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction
  // first order lag, tc in 10 ms units, zero passes through
  function automatic ppfr_val_t lag(input ppfr_val_t y, x,
                                    input logic [15:0] tc);
    ppfr_val_t den;
    den = $signed({16'h0, tc}) * $signed(`PPFR_TICKS_PER_10MS) + 32'sh1;
    lag = y + (x - y) / den;
  endfunction
  function automatic logic [15:0] mix(input logic [15:0] a, b,
                                      input ppfr_val_t x, d1, d2);
    ppfr_val_t sa, sb, t;
    sa = $signed({16'h0, a});
    sb = $signed({16'h0, b});
    if (x <= d1)
      t = sa;
    else if (x >= d2)
      t = sb;
    else
      t = sa + (sb - sa) * (x - d1) / (d2 - d1);
    mix = t[15:0];
  endfunction

  logic [15:0] cfg_q [`PPFR_NREG];
  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] tick_cnt_q;
  logic tick_q;
  ppfr_state_t state_q;
  logic run_prev_q;
  logic [31:0] hold_cnt_q;
  ppfr_val_t tgt_r_q, fb_f_q, fb_prev_q, integ_q, out_pct_q, out_f_q;
  logic [31:0] loss_cnt_q;
  logic fault_q;
  logic signed [31:0] freq_q;

  // bus decode
  wire [4:0] reg_idx = I_AVS_ADDRESS[6:2];
  wire addr_ok = (I_AVS_ADDRESS[7] == 1'b0) &&
                 (reg_idx < 5'(`PPFR_NREG));
  wire req_w = I_AVS_READ | I_AVS_WRITE;
  wire wr_do = I_AVS_WRITE & ~wait_q & addr_ok;
  wire fault_clr = wr_do && (reg_idx == `PPFR_R_STATUS) &&
                   I_AVS_WRITEDATA[`PPFR_S_FAULT];

  wire [15:0] ctrl = cfg_q[`PPFR_R_CTRL];
  wire tick = tick_q;
  wire run_start = I_DRIVE_RUN & ~run_prev_q;
  wire active = I_DRIVE_RUN | ctrl[`PPFR_C_RUNSTOP];
  wire reverse = ctrl[`PPFR_C_REV] ^ I_DI_ACTION_INVERT;

  // source selection
  logic [15:0] tgt_src, fb_src;
  wire [16:0] ai13_sum = {1'b0, I_ANALOG_INPUT_ONE} +
                         {1'b0, I_ANALOG_INPUT_THREE};
  wire [15:0] full16 = 16'(`PPFR_FULL);
  always_comb
  begin
    case (ctrl[`PPFR_C_TSRC]) // RULE_01
      3'h0: tgt_src = cfg_q[`PPFR_R_TGT];
      3'h1: tgt_src = I_ANALOG_INPUT_ONE;
      3'h2: tgt_src = I_ANALOG_INPUT_TWO;
      3'h3: tgt_src = I_ANALOG_INPUT_THREE;
      3'h4: tgt_src = I_PULSE_FREQUENCY_INPUT;
      3'h5: tgt_src = I_COMM_VALUE;
      default: tgt_src = cfg_q[`PPFR_R_TGT];
    endcase
    case (ctrl[`PPFR_C_FSRC]) // RULE_02
      4'h0: fb_src = I_ANALOG_INPUT_ONE;
      4'h1: fb_src = I_ANALOG_INPUT_TWO;
      4'h2: fb_src = I_ANALOG_INPUT_THREE;
      4'h3: fb_src = (I_ANALOG_INPUT_ONE > I_ANALOG_INPUT_THREE) ?
                     I_ANALOG_INPUT_ONE - I_ANALOG_INPUT_THREE : 16'h0;
      4'h4: fb_src = I_PULSE_FREQUENCY_INPUT;
      4'h5: fb_src = I_COMM_VALUE;
      4'h6: fb_src = ai13_sum[15:0];
      4'h7: fb_src = (I_ANALOG_INPUT_ONE > I_ANALOG_INPUT_TWO) ?
                     I_ANALOG_INPUT_ONE : I_ANALOG_INPUT_TWO;
      4'h8: fb_src = (I_ANALOG_INPUT_ONE < I_ANALOG_INPUT_TWO) ?
                     I_ANALOG_INPUT_ONE : I_ANALOG_INPUT_TWO;
      default: fb_src = I_ANALOG_INPUT_ONE;
    endcase
  end
  // limit to the 0..100 % span
  wire ppfr_val_t tgt_in = clamp($signed({16'h0, tgt_src}), // RULE_21
                                 32'sh0, `PPFR_FULL);
  wire ppfr_val_t fb_in = (ctrl[`PPFR_C_FSRC] == 4'h6 &&
                           ai13_sum > 17'(full16))
                          ? `PPFR_FULL
                          : clamp($signed({16'h0, fb_src}), 32'sh0, `PPFR_FULL);

  // setpoint ramp
  wire ppfr_val_t chg_t = $signed({16'h0, cfg_q[`PPFR_R_CHGT]});
  wire ppfr_val_t ramp_step = (chg_t == 32'sh0) ? `PPFR_FULL :
         clamp(`PPFR_RAMP_NUM / chg_t, 32'sh1, `PPFR_FULL); // RULE_11
  wire ppfr_val_t tgt_r_d = tgt_r_q +
         clamp(tgt_in - tgt_r_q, -ramp_step, ramp_step);

  // deviation and gain set
  wire ppfr_val_t err = reverse ? // RULE_03
         fb_f_q - tgt_r_q : tgt_r_q - fb_f_q;
  wire ppfr_val_t abs_err = (err < 32'sh0) ? -err : err;
  wire dead = abs_err < $signed({16'h0, cfg_q[`PPFR_R_DEVLIM]}); // RULE_09
  wire [1:0] sw_mode = ctrl[`PPFR_C_SWMODE];
  wire ppfr_val_t sw1 = $signed({16'h0, cfg_q[`PPFR_R_SWDEV1]});
  wire ppfr_val_t sw2 = $signed({16'h0, cfg_q[`PPFR_R_SWDEV2]});
  wire set2 = (sw_mode == 2'h1) && I_DI_GAIN_SET_TWO; // RULE_13
  wire auto_sw = (sw_mode == 2'h2);
  wire [15:0] kp = auto_sw ? // RULE_14
         mix(cfg_q[`PPFR_R_KP1], cfg_q[`PPFR_R_KP2], abs_err, sw1, sw2) :
         (set2 ? cfg_q[`PPFR_R_KP2] : cfg_q[`PPFR_R_KP1]);
  wire [15:0] ti = auto_sw ?
         mix(cfg_q[`PPFR_R_TI1], cfg_q[`PPFR_R_TI2], abs_err, sw1, sw2) :
         (set2 ? cfg_q[`PPFR_R_TI2] : cfg_q[`PPFR_R_TI1]);
  wire [15:0] td = auto_sw ?
         mix(cfg_q[`PPFR_R_TD1], cfg_q[`PPFR_R_TD2], abs_err, sw1, sw2) :
         (set2 ? cfg_q[`PPFR_R_TD2] : cfg_q[`PPFR_R_TD1]);

  // terms in 0.01 % of maximum frequency
  wire ppfr_val_t p_term = // RULE_05
         $signed({16'h0, kp}) * err / `PPFR_KP_UNITY;
  wire ppfr_val_t ti_ticks = clamp($signed({16'h0, ti}), 32'sh1,
         32'sh7FFF) * $signed(`PPFR_TICKS_PER_10MS);
  wire ppfr_val_t integ_inc = (err <<< `PPFR_ACC_SH) / ti_ticks; // RULE_06
  wire ppfr_val_t acc_lim = `PPFR_FULL <<< `PPFR_ACC_SH;
  wire ppfr_val_t i_term = integ_q >>> `PPFR_ACC_SH;
  wire ppfr_val_t dfb = reverse ? fb_f_q - fb_prev_q : fb_prev_q - fb_f_q;
  wire ppfr_val_t d_raw = dfb * $signed({16'h0, td}) /
         $signed(`PPFR_TICK_MS); // RULE_07
  wire ppfr_val_t dlim = $signed({16'h0, cfg_q[`PPFR_R_DIFLIM]});
  wire ppfr_val_t d_term = clamp(d_raw, -dlim, dlim); // RULE_10
  wire ppfr_val_t sum_raw = p_term + i_term + d_term; // RULE_22
  wire ppfr_val_t sum_c = clamp(sum_raw, -`PPFR_FULL, `PPFR_FULL);
  wire at_limit = (sum_raw != sum_c) || (out_pct_q != sum_c);
  wire integ_en = tick && (state_q == PPFR_RUN) && !dead &&
         !(ctrl[`PPFR_C_PAUSE_EN] && I_DI_INTEG_PAUSE) && // RULE_17
         !(ctrl[`PPFR_C_LIMSTOP] && at_limit); // RULE_18

  // output step limit
  wire ppfr_val_t step_f = $signed({16'h0, cfg_q[`PPFR_R_STEPF]});
  wire ppfr_val_t step_r = $signed({16'h0, cfg_q[`PPFR_R_STEPR]});
  wire ppfr_val_t out_step = clamp(sum_c - out_pct_q, -step_r,
                                   step_f); // RULE_16
  wire ppfr_val_t init_v = $signed({16'h0, cfg_q[`PPFR_R_INIT]});
  wire ppfr_val_t out_pct_d = (state_q == PPFR_HOLD) ? init_v : // RULE_15
         ((state_q == PPFR_RUN && !dead) ? out_pct_q + out_step :
         out_pct_q);
  wire ppfr_val_t out_f_d = lag(out_f_q, out_pct_d,
                                cfg_q[`PPFR_R_OUTFLT]); // RULE_12
  wire ppfr_val_t fmax = $signed({16'h0, cfg_q[`PPFR_R_FMAX]});
  wire ppfr_val_t rev_cut = $signed({16'h0, cfg_q[`PPFR_R_REVCUT]});
  wire ppfr_val_t freq_raw = out_f_q * fmax / `PPFR_FULL; // RULE_22
  wire ppfr_val_t freq_d = (freq_raw < -rev_cut) ? -rev_cut : // RULE_08
                           freq_raw;

  // feedback loss timing, in ticks
  wire [31:0] loss_lim = 32'(cfg_q[`PPFR_R_LOSST]) * `PPFR_TICKS_PER_100MS;
  wire loss_low = (cfg_q[`PPFR_R_LOSSTHR] != 16'h0) && // RULE_19
         (fb_f_q < $signed({16'h0, cfg_q[`PPFR_R_LOSSTHR]}));
  wire loss_hit = tick && loss_low && (loss_cnt_q >= loss_lim);
  wire [31:0] hold_ticks = 32'(cfg_q[`PPFR_R_HOLDT]) *
                           `PPFR_TICKS_PER_10MS;

  // display values
  wire [31:0] tgt_disp = 32'(tgt_r_q[15:0]) * 32'(cfg_q[`PPFR_R_RANGE]) /
                         32'(`PPFR_FULL); // RULE_04
  wire [31:0] fb_disp = 32'(fb_f_q[15:0]) * 32'(cfg_q[`PPFR_R_RANGE]) /
                        32'(`PPFR_FULL);
  wire [15:0] status_w = {13'h0, set2, state_q == PPFR_HOLD, fault_q};
  wire [31:0] rd_w = !addr_ok ? 32'h0 :
         (reg_idx == `PPFR_R_STATUS) ? {16'h0, status_w} :
         (reg_idx == `PPFR_R_TGTDISP) ? tgt_disp :
         (reg_idx == `PPFR_R_FBDISP) ? fb_disp :
         (reg_idx == `PPFR_R_OUT) ? out_f_q :
         {16'h0, cfg_q[reg_idx]};

  function automatic logic [15:0] rst_val(input int i);
    case (5'(i))
      `PPFR_R_TGT: rst_val = `PPFR_RV_TGT;
      `PPFR_R_RANGE: rst_val = `PPFR_RV_RANGE;
      `PPFR_R_KP1, `PPFR_R_KP2: rst_val = `PPFR_RV_KP;
      `PPFR_R_TI1, `PPFR_R_TI2: rst_val = `PPFR_RV_TI;
      `PPFR_R_REVCUT: rst_val = `PPFR_RV_REVCUT;
      `PPFR_R_DEVLIM: rst_val = `PPFR_RV_DEVLIM;
      `PPFR_R_DIFLIM: rst_val = `PPFR_RV_DIFLIM;
      `PPFR_R_SWDEV1: rst_val = `PPFR_RV_SWDEV1;
      `PPFR_R_SWDEV2: rst_val = `PPFR_RV_SWDEV2;
      `PPFR_R_STEPF, `PPFR_R_STEPR: rst_val = `PPFR_RV_STEP;
      `PPFR_R_LOSST: rst_val = `PPFR_RV_LOSST;
      `PPFR_R_FMAX: rst_val = `PPFR_RV_FMAX;
      default: rst_val = 16'h0;
    endcase
  endfunction

  // register file, one cycle of wait on every access
  genvar g;
  for (g = 0; g < `PPFR_NWR; g++)
  begin : g_cfg
    always_ff @(posedge I_MCLK)
    begin
      if (!I_RST_B)
        cfg_q[g] <= rst_val(g);
      else if (wr_do && reg_idx == 5'(g))
        cfg_q[g] <= I_AVS_WRITEDATA[15:0];
    end
  end
  for (g = `PPFR_NWR; g < `PPFR_NREG; g++)
  begin : g_ro
    always_comb cfg_q[g] = 16'h0;
  end

  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_B)
    begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
    end
    else
    begin
      wait_q <= ~(req_w & wait_q);
      if (req_w & wait_q)
        rdata_q <= rd_w;
    end
  end

  // 2 ms update strobe
  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_B || tick_cnt_q == 32'(TICK_CYC - 1))
      tick_cnt_q <= 32'h0;
    else
      tick_cnt_q <= tick_cnt_q + 32'h1;
    tick_q <= I_RST_B && (tick_cnt_q == 32'(TICK_CYC - 1)); // RULE_16
  end

  // run state
  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_B)
    begin
      state_q <= PPFR_IDLE; // RULE_23
      run_prev_q <= 1'b0;
      hold_cnt_q <= 32'h0;
    end
    else
    begin
      run_prev_q <= I_DRIVE_RUN;
      case (state_q)
        PPFR_IDLE:
          if (run_start)
            state_q <= PPFR_HOLD;
          else if (active)
            state_q <= PPFR_RUN; // RULE_20
        PPFR_HOLD:
          if (!I_DRIVE_RUN)
            state_q <= PPFR_IDLE;
          else if (tick && hold_cnt_q >= hold_ticks)
            state_q <= PPFR_RUN; // RULE_15
        PPFR_RUN:
          if (!active)
            state_q <= PPFR_IDLE; // RULE_20
          else if (run_start)
            state_q <= PPFR_HOLD;
        default: state_q <= PPFR_IDLE;
      endcase
      if (state_q != PPFR_HOLD)
        hold_cnt_q <= 32'h0;
      else if (tick)
        hold_cnt_q <= hold_cnt_q + 32'h1;
    end
  end

  // regulator datapath
  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_B)
    begin
      tgt_r_q <= 32'sh0; // RULE_23
      fb_f_q <= 32'sh0;
      fb_prev_q <= 32'sh0;
      integ_q <= 32'sh0;
      out_pct_q <= 32'sh0;
      out_f_q <= 32'sh0;
      freq_q <= 32'sh0;
    end
    else if (tick)
    begin
      tgt_r_q <= tgt_r_d;
      fb_f_q <= lag(fb_f_q, fb_in, cfg_q[`PPFR_R_FBFLT]); // RULE_12
      fb_prev_q <= fb_f_q;
      if (state_q == PPFR_HOLD)
        integ_q <= 32'sh0;
      else if (integ_en)
        integ_q <= clamp(integ_q + integ_inc, -acc_lim, acc_lim);
      out_pct_q <= out_pct_d;
      out_f_q <= out_f_d;
      freq_q <= freq_d;
    end
  end

  // feedback loss, set wins over a clear in the same cycle
  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_B)
    begin
      loss_cnt_q <= 32'h0; // RULE_23
      fault_q <= 1'b0;
    end
    else
    begin
      if (!loss_low)
        loss_cnt_q <= 32'h0;
      else if (tick && loss_cnt_q <= loss_lim)
        loss_cnt_q <= loss_cnt_q + 32'h1;
      fault_q <= loss_hit | (fault_q & ~fault_clr); // RULE_19
    end
  end

  assign O_AVS_WAITREQUEST = wait_q;
  assign O_AVS_READDATA = rdata_q;
  assign O_FREQ_CORR = freq_q;
  assign O_UPDATE = tick_q;
  assign O_FEEDBACK_LOSS_FAULT = fault_q;

  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_B);
  sequence s_tick_run;
    tick && state_q == PPFR_RUN && !dead;
  endsequence
  sequence s_hold_tick;
    tick && state_q == PPFR_HOLD;
  endsequence
  AST_OUT_ONLY_ON_TICK: assert property (!tick |=> // RULE_22
      $stable(out_pct_q))
    else $error("output moved between updates");
  AST_STEP_LIMIT: assert property (s_tick_run |=> // RULE_16
      (out_pct_q - $past(out_pct_q) <= step_f) &&
      ($past(out_pct_q) - out_pct_q <= step_r))
    else $error("output step exceeds limit");
  AST_REV_CAP: assert property (freq_q >= -rev_cut) // RULE_08
    else $error("reverse frequency above cut-off");
  AST_DIFF_CLAMP: assert property (d_term <= dlim && d_term >= -dlim) // RULE_10
    else $error("differential term out of range");
  AST_HOLD_INIT: assert property (s_hold_tick |=> out_pct_q == init_v) // RULE_15
    else $error("output not at initial value in hold");
  AST_DEADBAND: assert property (tick && dead |=> $stable(integ_q)) // RULE_09
    else $error("integral moved inside deviation limit");
  AST_PAUSE: assert property (tick && ctrl[`PPFR_C_PAUSE_EN] && // RULE_17
      I_DI_INTEG_PAUSE && state_q == PPFR_RUN |=> $stable(integ_q))
    else $error("integral moved while paused");
  AST_FAULT_STICKY: assert property (fault_q && !fault_clr |=> // RULE_19
      fault_q)
    else $error("loss fault dropped without clear");
  AST_FAULT_SET: assert property (loss_hit |=> fault_q) // RULE_19
    else $error("loss fault not raised");
  AST_BUS_ANSWER: assert property (req_w && wait_q |=> !wait_q ##1 wait_q)
    else $error("bus answer not one cycle after request");
  AST_RESET_CLEAR: assert property (disable iff (1'b0) // RULE_23
      !I_RST_B |=> integ_q == 32'sh0 && fb_f_q == 32'sh0 &&
      tgt_r_q == 32'sh0 && loss_cnt_q == 32'h0)
    else $error("reset left regulator state");
endmodule
`default_nettype wire

//--- testbench/ppfr_plant.sv
`default_nettype none
module ppfr_plant
(
  input wire logic i_clk,
  input wire logic i_load,
  input wire logic [79:0] i_vals,
  input wire logic i_loss,
  input wire logic signed [31:0] i_freq_corr,
  input wire logic i_update,
  output logic [15:0] o_analog_one,
  output logic [15:0] o_analog_two,
  output logic [15:0] o_analog_three,
  output logic [15:0] o_pulse,
  output logic [15:0] o_comm,
  output logic signed [31:0] o_freq_ref
);
  logic [79:0] sens_q = 80'h0;
  logic signed [31:0] ref_q = 32'sh0;
  logic [79:0] sens;
  // a disconnected sensor reads zero
  assign sens = i_loss ? 80'h0 : sens_q;
  assign o_analog_one = sens[79:64];
  assign o_analog_two = sens[63:48];
  assign o_analog_three = sens[47:32];
  assign o_pulse = sens[31:16];
  assign o_comm = sens[15:0];
  assign o_freq_ref = ref_q;
  // reference accepted only on the update strobe
  always @(posedge i_clk)
  begin
    if (i_load)
      sens_q <= i_vals;
    if (i_update)
      ref_q <= i_freq_corr;
  end
endmodule
`default_nettype wire

//--- testbench/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int tick_cyc = 20;
  localparam logic [7:0] a_ctrl = 8'h00, a_tgt = 8'h04, a_range = 8'h08,
    a_init = 8'h44, a_holdt = 8'h48, a_lthr = 8'h54, a_lt = 8'h58,
    a_stat = 8'h60, a_tdisp = 8'h64, a_fdisp = 8'h68, a_out = 8'h6C;
  logic clk = 1'b0, rst_b = 1'b0, rd_en = 1'b0, wr_en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic waitreq, upd, fault, load = 1'b0, loss = 1'b0;
  logic run = 1'b0, inv = 1'b0, gs2 = 1'b0, pause = 1'b0;
  logic [79:0] vals = 80'h0;
  logic [15:0] a1, a2, a3, pf, cm;
  logic signed [31:0] freq, fref;
  int fails = 0, check_count = 0;
  logic [7:0] rv_a [14] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18,
    8'h24, 8'h28, 8'h2C, 8'h3C, 8'h40, 8'h4C, 8'h50, 8'h54};
  logic [15:0] rv_v [14] = '{16'h0000, 16'h1388, 16'h03E8, 16'h00C8,
    16'h00C8, 16'h00C8, 16'h00C8, 16'h0001, 16'h000A, 16'h07D0, 16'h1F40,
    16'h0064, 16'h0064, 16'h0000};

  ppfr_top #(.TICK_CYC(tick_cyc)) u_dut (.I_MCLK(clk), .I_RST_B(rst_b),
    .I_AVS_ADDRESS(addr), .I_AVS_READ(rd_en), .I_AVS_WRITE(wr_en),
    .I_AVS_WRITEDATA(wdata), .O_AVS_READDATA(rdata),
    .O_AVS_WAITREQUEST(waitreq), .I_ANALOG_INPUT_ONE(a1),
    .I_ANALOG_INPUT_TWO(a2), .I_ANALOG_INPUT_THREE(a3),
    .I_PULSE_FREQUENCY_INPUT(pf), .I_COMM_VALUE(cm), .I_DRIVE_RUN(run),
    .I_DI_ACTION_INVERT(inv), .I_DI_GAIN_SET_TWO(gs2),
    .I_DI_INTEG_PAUSE(pause), .O_FREQ_CORR(freq), .O_UPDATE(upd),
    .O_FEEDBACK_LOSS_FAULT(fault));
  ppfr_plant u_plant (.i_clk(clk), .i_load(load), .i_vals(vals),
    .i_loss(loss), .i_freq_corr(freq), .i_update(upd), .o_analog_one(a1),
    .o_analog_two(a2), .o_analog_three(a3), .o_pulse(pf), .o_comm(cm),
    .o_freq_ref(fref));

  initial
  begin
    forever #5 clk = ~clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask

  task automatic bus(input logic wr, input logic [7:0] ad,
                     input logic [15:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    addr <= ad;
    wdata <= {16'h0, d};
    rd_en <= !wr;
    wr_en <= wr;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitreq !== 1'b0 && n < 50);
    q = rdata;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    if (n >= 50)
      chk_bit(waitreq, 1'b0);
  endtask

  task automatic reg_wr(input logic [7:0] ad, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, ad, d, q);
  endtask

  task automatic reg_rd(input logic [7:0] ad, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, ad, 16'h0, q);
    chk_val(q, exp);
  endtask

  task automatic wait_ticks(input int n);
    repeat (n) @(posedge clk iff upd === 1'b1);
    @(negedge clk);
  endtask

  task automatic sens(input logic [79:0] v);
    @(posedge clk);
    vals <= v;
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_b <= 1'b0;
    run <= 1'b0;
    inv <= 1'b0;
    loss <= 1'b0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
  endtask

  task automatic start_run();
    @(posedge clk);
    run <= 1'b1;
  endtask

  task automatic t_regs();
    for (int i = 0; i < 14; i++)
      reg_rd(rv_a[i], {16'h0, rv_v[i]});
    reg_wr(8'h70, 16'h1234);
    reg_rd(8'h70, 32'h0);
    reg_rd(8'h80, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_tick();
    int n;
    wait_ticks(1);
    chk_bit(upd, 1'b0);
    n = 1;
    while (upd !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    chk_bit(upd, 1'b1);
    chk_val(32'(n), 32'(tick_cyc));
    $display("test tick done");
  endtask

  task automatic t_sources();
    logic [15:0] te [6];
    logic [15:0] fe [9];
    te = '{16'h1A0A, 16'h0457, 16'h08AE, 16'h0D05, 16'h115C, 16'h15B3};
    fe = '{16'h0457, 16'h08AE, 16'h0D05, 16'h0000, 16'h115C, 16'h15B3,
      16'h115C, 16'h08AE, 16'h0457};
    sens({16'h0457, 16'h08AE, 16'h0D05, 16'h115C, 16'h15B3});
    start_run();
    reg_wr(a_range, 16'h2710);
    reg_wr(a_tgt, 16'h1A0A);
    for (int i = 0; i < 6; i++)
    begin
      reg_wr(a_ctrl, {13'h0, 3'(i)});
      wait_ticks(3);
      reg_rd(a_tdisp, {16'h0, te[i]});
    end
    for (int i = 0; i < 9; i++)
    begin
      reg_wr(a_ctrl, {9'h0, 4'(i), 3'h0});
      wait_ticks(3);
      reg_rd(a_fdisp, {16'h0, fe[i]});
    end
    sens({16'h1F40, 16'h0000, 16'h1388, 32'h0});
    reg_wr(a_range, 16'h07D0);
    reg_wr(a_tgt, 16'h2710);
    reg_wr(a_ctrl, 16'h0030);
    wait_ticks(3);
    reg_rd(a_tdisp, 32'h07D0);
    reg_rd(a_fdisp, 32'h07D0);
    $display("test sources done");
  endtask

  task automatic t_direction();
    do_reset();
    sens(80'h0);
    reg_wr(a_tgt, 16'h2710);
    reg_wr(a_ctrl, 16'h0080);
    start_run();
    wait_ticks(12);
    chk_val(fref, 32'hFFFF_FF38);
    chk_bit(fault, 1'b0);
    @(posedge clk);
    inv <= 1'b1;
    wait_ticks(40);
    chk_bit(fref > 0, 1'b1);
    reg_wr(a_ctrl, 16'h0000);
    wait_ticks(40);
    chk_val(fref, 32'hFFFF_FF38);
    @(posedge clk);
    inv <= 1'b0;
    wait_ticks(40);
    chk_bit(fref > 0, 1'b1);
    $display("test direction done");
  endtask

  task automatic t_deadband();
    do_reset();
    sens({16'h1388, 64'h0});
    start_run();
    wait_ticks(20);
    chk_val(freq, 32'h0);
    sens({16'h0FA0, 64'h0});
    wait_ticks(10);
    chk_bit(freq > 0, 1'b1);
    $display("test deadband done");
  endtask

  task automatic t_hold();
    do_reset();
    reg_wr(a_init, 16'h0BB8);
    reg_wr(a_holdt, 16'h0002);
    start_run();
    wait_ticks(3);
    reg_rd(a_stat, 32'h0000_0002);
    reg_rd(a_out, 32'h0000_0BB8);
    wait_ticks(15);
    reg_rd(a_stat, 32'h0);
    $display("test hold done");
  endtask

  task automatic t_loss();
    do_reset();
    sens({16'h1388, 64'h0});
    @(posedge clk);
    loss <= 1'b1;
    reg_wr(a_lthr, 16'h03E8);
    reg_wr(a_lt, 16'h0001);
    start_run();
    wait_ticks(45);
    chk_bit(fault, 1'b0);
    wait_ticks(15);
    chk_bit(fault, 1'b1);
    @(posedge clk);
    loss <= 1'b0;
    wait_ticks(5);
    chk_bit(fault, 1'b1);
    reg_rd(a_stat, 32'h0000_0001);
    reg_wr(a_stat, 16'h0001);
    wait_ticks(2);
    chk_bit(fault, 1'b0);
    $display("test loss done");
  endtask

  task automatic t_gain();
    reg_wr(a_ctrl, 16'h0100);
    @(posedge clk);
    gs2 <= 1'b1;
    wait_ticks(2);
    reg_rd(a_stat, 32'h0000_0004);
    @(posedge clk);
    gs2 <= 1'b0;
    wait_ticks(2);
    reg_rd(a_stat, 32'h0);
    $display("test gain done");
  endtask

  task automatic t_pause();
    do_reset();
    reg_wr(8'h0C, 16'h0000);
    reg_wr(a_ctrl, 16'h0400);
    reg_wr(a_tgt, 16'h2710);
    @(posedge clk);
    pause <= 1'b1;
    run <= 1'b1;
    wait_ticks(10);
    chk_val(freq, 32'h0);
    @(posedge clk);
    pause <= 1'b0;
    wait_ticks(10);
    chk_bit(freq > 0, 1'b1);
    $display("test pause done");
  endtask

  initial
  begin
    #200000;
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    stop_test();
  end

  initial
  begin
    do_reset();
    t_regs();
    t_tick();
    t_sources();
    t_direction();
    t_deadband();
    t_hold();
    t_loss();
    t_gain();
    t_pause();
    stop_test();
  end
endmodule
`default_nettype wire
